// file: rtl/asim_master.sv
`timescale 1ns/1ps
`include "asim_defines.svh"
module asim_master
    import asim_pkg::*;
#(
    parameter int EXT_BYTES  = `ASIM_EXT_BYTES,
    parameter int FIFO_BYTES = `ASIM_FIFO_BYTES
) (
    input  wire logic                                 ref_clk,
    input  wire logic                                 sys_rst,
    input  wire logic                                 bypass_en,
    input  wire logic                                 spi_mode,
    input  wire logic                                 master_en,
    input  wire logic                                 sample_tick,
    input  wire logic                                 ch4_start,
    input  wire asim_chan_cfg_t [4:0]                 chan_cfg,
    input  wire logic                                 fifo_rd,
    input  wire logic                                 host_scl_i,
    input  wire logic                                 host_sda_i,
    input  wire logic                                 sensor_bus_clock_line_i,
    input  wire logic                                 sensor_bus_data_line_i,
    output logic                                      host_scl_o,
    output logic                                      host_scl_oe,
    output logic                                      host_sda_o,
    output logic                                      host_sda_oe,
    output logic                                      sensor_bus_clock_line_o,
    output logic                                      sensor_bus_clock_line_oe,
    output logic                                      sensor_bus_data_line_o,
    output logic                                      sensor_bus_data_line_oe,
    output logic                                      bypass_active,
    output logic [EXT_BYTES*8-1:0]                    ext_data,
    output logic [7:0]                                ch4_rdata,
    output logic                                      ch4_done,
    output logic                                      nack_evt,
    output logic                                      arb_lost_evt,
    output logic [7:0]                                fifo_rdata,
    output logic [$clog2(FIFO_BYTES+1)-1:0]           fifo_count
);
    localparam int QTR = `ASIM_QTR_CYC;
    localparam int QW  = $clog2(QTR);
    localparam int AW  = $clog2(FIFO_BYTES);
    localparam int CW  = $clog2(FIFO_BYTES + 1);
    localparam int IW  = $clog2(EXT_BYTES + 1);

    if (EXT_BYTES < 1 || EXT_BYTES > 24 || FIFO_BYTES < 2 || (FIFO_BYTES & (FIFO_BYTES - 1)) != 0)
    begin : g_bad_param
        $error("asim_master: EXT_BYTES must be 1..24, FIFO_BYTES a power of two");
    end

    function automatic logic [2:0] first_pend(input logic [4:0] p);
        first_pend = `ASIM_CH4;
        for (int i = 4; i >= 0; i--) begin
            if (p[i]) begin
                first_pend = 3'(i);
            end
        end
    endfunction

    logic [3:0]     s1_r;
    logic [3:0]     s2_r;
    logic           h_scl, h_sda, a_scl, a_sda;
    logic           byp_r, zero_r;
    logic [2:0]     gh_r, ga_r;
    asim_state_t    st_r;
    asim_kind_t     kind_r;
    logic [1:0]     ph_r;
    logic [3:0]     bit_r, left_r;
    logic [7:0]     sh_r;
    logic [2:0]     cur_r, pick_w;
    logic [4:0]     pend_r;
    logic [3:0]     req_mask;
    logic [IW-1:0]  idx_r;
    logic [QW-1:0]  q_r;
    logic           m_scl_lo_r, m_sda_lo_r, ack_r;
    logic           qtick, rx, to_fifo, push_ok, want_push, tick_ok;
    logic           buf_in_valid, buf_in_ready, buf_out_valid, buf_out_ready;
    logic [7:0]     buf_out_data;
    logic           f_push, f_pop;
    logic [7:0]     fmem [FIFO_BYTES];
    logic [AW-1:0]  fwp_r, frp_r;
    asim_chan_cfg_t cfg;

    assign {h_scl, h_sda, a_scl, a_sda} = s2_r;

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            s1_r <= `ASIM_SYNC_RST;
            s2_r <= `ASIM_SYNC_RST;
        end else begin
            s1_r <= {host_scl_i, host_sda_i, sensor_bus_clock_line_i, sensor_bus_data_line_i};
            s2_r <= s1_r;
        end
    end

    // Open-drain pins only ever pull low; the data bits stay zero
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            zero_r <= 1'b0;
        end else begin
            zero_r <= 1'b0;
        end
    end
    assign host_scl_o              = zero_r;
    assign host_scl_oe             = zero_r;
    assign host_sda_o              = zero_r;
    assign sensor_bus_clock_line_o = zero_r;
    assign sensor_bus_data_line_o  = zero_r;
    assign bypass_active           = byp_r;

    // Data relay works both ways; after one side is released its own echo is
    // ignored for a few cycles, otherwise the two sides would hold each other low
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            byp_r                    <= 1'b0;
            sensor_bus_clock_line_oe <= 1'b0;
            sensor_bus_data_line_oe  <= 1'b0;
            host_sda_oe              <= 1'b0;
            gh_r                     <= '0;
            ga_r                     <= '0;
        end else begin
            byp_r                    <= bypass_en && !spi_mode;
            sensor_bus_clock_line_oe <= byp_r ? !h_scl : m_scl_lo_r;
            sensor_bus_data_line_oe  <= byp_r ? (!h_sda && !host_sda_oe && gh_r == '0)
                                              : m_sda_lo_r;
            host_sda_oe              <= byp_r && !a_sda && !sensor_bus_data_line_oe && ga_r == '0;
            gh_r <= host_sda_oe ? `ASIM_GUARD_CYC : (gh_r != '0 ? gh_r - 3'h1 : gh_r);
            ga_r <= sensor_bus_data_line_oe ? `ASIM_GUARD_CYC : (ga_r != '0 ? ga_r - 3'h1 : ga_r);
        end
    end

    always_comb begin
        for (int i = 0; i < 4; i++) begin
            req_mask[i] = chan_cfg[i].en && (!chan_cfg[i].rd || chan_cfg[i].len != 4'h0);
        end
    end

    assign cfg       = chan_cfg[cur_r];
    assign pick_w    = first_pend(pend_r);
    assign qtick     = q_r == QW'(QTR - 1);
    assign rx        = kind_r == K_RD;
    assign to_fifo   = cur_r != `ASIM_CH4 && cfg.to_fifo;
    assign push_ok   = !to_fifo || buf_in_ready;
    assign want_push = st_r == ST_BYTE && rx && bit_r == 4'd8 && ph_r == 2'd0 && qtick;
    assign tick_ok   = sample_tick && master_en && !byp_r;
    assign buf_in_valid = want_push && to_fifo;

    // Quarter-bit timer; cleared to zero while a released clock line is still low (stretching)
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            q_r <= '0;
        end else if (st_r == ST_IDLE || (!m_scl_lo_r && !a_scl) || qtick) begin
            q_r <= '0;
        end else begin
            q_r <= q_r + 1'b1;
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_r       <= ST_IDLE;
            kind_r     <= K_ADDRW;
            ph_r       <= '0;
            bit_r      <= '0;
            left_r     <= '0;
            sh_r       <= '0;
            cur_r      <= '0;
            pend_r     <= '0;
            idx_r      <= '0;
            ack_r      <= 1'b0;
            m_scl_lo_r <= 1'b0;
            m_sda_lo_r <= 1'b0;
            nack_evt   <= 1'b0;
            arb_lost_evt <= 1'b0;
            ch4_done   <= 1'b0;
            ch4_rdata  <= '0;
            ext_data   <= '0;
        end else begin
            nack_evt     <= 1'b0;
            arb_lost_evt <= 1'b0;
            ch4_done     <= 1'b0;
            if (byp_r) begin
                st_r       <= ST_IDLE;
                m_scl_lo_r <= 1'b0;
                m_sda_lo_r <= 1'b0;
            end else begin
                case (st_r)
                    ST_IDLE: begin
                        if (pend_r != 5'h0) begin
                            cur_r <= pick_w;
                            st_r  <= ST_START;
                            ph_r  <= 2'd0;
                        end
                    end
                    ST_START, ST_RSTART, ST_STOP: begin
                        if (qtick) begin
                            ph_r <= ph_r + 2'd1;
                            case (ph_r)
                                2'd0: m_sda_lo_r <= st_r == ST_STOP;
                                2'd1: begin
                                    if (st_r == ST_START) begin
                                        m_sda_lo_r <= 1'b1;
                                    end else begin
                                        m_scl_lo_r <= 1'b0;
                                    end
                                end
                                2'd2: m_sda_lo_r <= st_r != ST_STOP;
                                default: begin
                                    if (st_r == ST_STOP) begin
                                        st_r          <= ST_IDLE;
                                        pend_r[cur_r] <= 1'b0;
                                        ch4_done      <= cur_r == `ASIM_CH4;
                                    end else begin
                                        m_scl_lo_r <= 1'b1;
                                        st_r       <= ST_BYTE;
                                        bit_r      <= '0;
                                        kind_r     <= st_r == ST_START ? K_ADDRW : K_ADDRR;
                                        sh_r       <= {cfg.dev, st_r != ST_START};
                                    end
                                end
                            endcase
                        end
                    end
                    ST_BYTE: begin
                        if (qtick) begin
                            case (ph_r)
                                2'd0: begin
                                    // A full buffer stalls here with the clock held low
                                    if (push_ok) begin
                                        ph_r <= 2'd1;
                                        if (bit_r == 4'd8) begin
                                            m_sda_lo_r <= rx && left_r > 4'h1;
                                            if (rx && cur_r == `ASIM_CH4) begin
                                                ch4_rdata <= sh_r;
                                            end else if (rx && int'(idx_r) < EXT_BYTES) begin
                                                ext_data[int'(idx_r) * 8 +: 8] <= sh_r;
                                                idx_r <= idx_r + 1'b1;
                                            end
                                        end else begin
                                            m_sda_lo_r <= !rx && !sh_r[7];
                                        end
                                    end
                                end
                                2'd1: begin
                                    m_scl_lo_r <= 1'b0;
                                    ph_r       <= 2'd2;
                                end
                                2'd2: begin
                                    ph_r <= 2'd3;
                                    if (bit_r == 4'd8) begin
                                        ack_r <= a_sda;
                                    end else if (rx) begin
                                        sh_r <= {sh_r[6:0], a_sda};
                                    end else if (sh_r[7] && !a_sda) begin
                                        st_r          <= ST_IDLE;
                                        m_sda_lo_r    <= 1'b0;
                                        arb_lost_evt  <= 1'b1;
                                        pend_r[cur_r] <= 1'b0;
                                    end else begin
                                        sh_r <= {sh_r[6:0], 1'b0};
                                    end
                                end
                                default: begin
                                    m_scl_lo_r <= 1'b1;
                                    ph_r       <= 2'd0;
                                    bit_r      <= bit_r + 4'h1;
                                    if (bit_r == 4'd8) begin
                                        bit_r <= '0;
                                        if (rx) begin
                                            left_r <= left_r - 4'h1;
                                            if (left_r == 4'h1) begin
                                                st_r <= ST_STOP;
                                            end
                                        end else if (ack_r || kind_r == K_WR) begin
                                            st_r     <= ST_STOP;
                                            nack_evt <= ack_r;
                                        end else if (kind_r == K_ADDRW) begin
                                            kind_r <= K_REG;
                                            sh_r   <= cfg.reg_a;
                                        end else if (kind_r == K_ADDRR) begin
                                            kind_r <= K_RD;
                                            left_r <= cur_r == `ASIM_CH4 ? 4'h1 : cfg.len;
                                        end else if (cfg.rd) begin
                                            st_r <= ST_RSTART;
                                        end else begin
                                            kind_r <= K_WR;
                                            sh_r   <= cfg.wdata;
                                        end
                                    end
                                end
                            endcase
                        end
                    end
                    default: st_r <= ST_IDLE;
                endcase
            end
            // Written last so a new request wins over the clear of the old one
            for (int i = 0; i < 4; i++) begin
                if (tick_ok && req_mask[i]) begin
                    pend_r[i] <= 1'b1;
                end
            end
            if (tick_ok) begin
                idx_r <= '0;
            end
            if (ch4_start && master_en && !byp_r) begin
                pend_r[4] <= 1'b1;
            end
        end
    end

    asim_buf2 #(
        .W     (8),
        .DEPTH (`ASIM_BUF_DEPTH)
    ) u_buf (
        .ref_clk   (ref_clk),
        .sys_rst   (sys_rst),
        .in_valid  (buf_in_valid),
        .in_data   (sh_r),
        .in_ready  (buf_in_ready),
        .out_valid (buf_out_valid),
        .out_data  (buf_out_data),
        .out_ready (buf_out_ready)
    );

    assign buf_out_ready = fifo_count != CW'(FIFO_BYTES);
    assign f_push        = buf_out_valid && buf_out_ready;
    assign f_pop         = fifo_rd && fifo_count != '0;

    always_ff @(posedge ref_clk) begin
        if (f_push) begin
            fmem[fwp_r] <= buf_out_data;
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            fwp_r      <= '0;
            frp_r      <= '0;
            fifo_count <= '0;
            fifo_rdata <= '0;
        end else begin
            if (f_push) begin
                fwp_r <= fwp_r + 1'b1;
            end
            if (f_pop) begin
                frp_r      <= frp_r + 1'b1;
                fifo_rdata <= fmem[frp_r];
            end
            fifo_count <= fifo_count + CW'(f_push) - CW'(f_pop);
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    property p_byp_idle;
        byp_r |=> st_r == ST_IDLE && !m_scl_lo_r && !m_sda_lo_r;
    endproperty
    a_byp_idle: assert property (p_byp_idle)
        else $error("bus master active during pass-through");

    property p_byp_scl;
        byp_r && !h_scl |=> sensor_bus_clock_line_oe;
    endproperty
    a_byp_scl: assert property (p_byp_scl)
        else $error("host clock low not relayed to sensor bus");

    property p_spi_block;
        spi_mode |=> !byp_r;
    endproperty
    a_spi_block: assert property (p_spi_block)
        else $error("pass-through active with SPI primary");

    property p_ch4_single;
        st_r == ST_BYTE && kind_r == K_RD && cur_r == `ASIM_CH4 |-> left_r == 4'h1;
    endproperty
    a_ch4_single: assert property (p_ch4_single)
        else $error("channel 4 read longer than one byte");

    property p_ext_cap;
        int'(idx_r) <= EXT_BYTES;
    endproperty
    a_ext_cap: assert property (p_ext_cap)
        else $error("sensor data index past its limit");

    property p_fifo_count;
        f_push && !f_pop |=> fifo_count == CW'($past(fifo_count) + 1'b1);
    endproperty
    a_fifo_count: assert property (p_fifo_count)
        else $error("fifo count did not follow a push");

    property p_nack_stop;
        nack_evt |-> st_r == ST_STOP && ph_r == 2'd0;
    endproperty
    a_nack_stop: assert property (p_nack_stop)
        else $error("missing acknowledge not followed by stop");

    property p_order;
        st_r == ST_IDLE && pend_r != 5'h0 && !byp_r |=> st_r == ST_START && cur_r == $past(pick_w);
    endproperty
    a_order: assert property (p_order)
        else $error("channel served out of order");

    property p_ch4_done;
        ch4_done |-> $past(st_r) == ST_STOP && $past(cur_r) == `ASIM_CH4 && st_r == ST_IDLE;
    endproperty
    a_ch4_done: assert property (p_ch4_done)
        else $error("channel 4 completion without its stop");

    property p_push_stall;
        want_push && to_fifo && !buf_in_ready && !byp_r |=> ph_r == 2'd0 && st_r == ST_BYTE;
    endproperty
    a_push_stall: assert property (p_push_stall)
        else $error("read byte dropped while buffer full");

    c_bypass: cover property (byp_r && !h_sda ##1 sensor_bus_data_line_oe);
    c_ch4: cover property (ch4_done);
    c_arb: cover property (arb_lost_evt);
    c_stall: cover property (want_push && to_fifo && !buf_in_ready);
    c_full: cover property (fifo_count == CW'(FIFO_BYTES));
endmodule

// file: rtl/asim_defines.svh
`ifndef ASIM_DEFINES_SVH
`define ASIM_DEFINES_SVH

`define ASIM_CLK_HZ     50000000
`define ASIM_SCL_HZ     400000
// Quarter of a sensor-bus clock period, rounded up so the bus never runs fast
`define ASIM_QTR_CYC    ((`ASIM_CLK_HZ + 4 * `ASIM_SCL_HZ - 1) / (4 * `ASIM_SCL_HZ))
`define ASIM_GUARD_CYC  3'h4
`define ASIM_CH4        3'h4
`define ASIM_EXT_BYTES  24
`define ASIM_FIFO_BYTES 512
`define ASIM_BUF_DEPTH  2
`define ASIM_SYNC_RST   4'hf

`endif

// file: rtl/asim_pkg.sv
package asim_pkg;

    typedef struct packed {
        logic       en;
        logic       rd;
        logic       to_fifo;
        logic [6:0] dev;
        logic [7:0] reg_a;
        logic [7:0] wdata;
        logic [3:0] len;
    } asim_chan_cfg_t;

    typedef enum logic [2:0] {ST_IDLE, ST_START, ST_BYTE, ST_RSTART, ST_STOP} asim_state_t;

    typedef enum logic [2:0] {K_ADDRW, K_REG, K_ADDRR, K_RD, K_WR} asim_kind_t;

endpackage

// file: rtl/asim_buf2.sv
`timescale 1ns/1ps

module asim_buf2 #(
    parameter int W     = 8,
    parameter int DEPTH = 2
) (
    input  wire logic         ref_clk,
    input  wire logic         sys_rst,
    input  wire logic         in_valid,
    input  wire logic [W-1:0] in_data,
    output logic              in_ready,
    output logic              out_valid,
    output logic [W-1:0]      out_data,
    input  wire logic         out_ready
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
        $error("asim_buf2: DEPTH must be a power of two, at least 2");
    end

    logic [W-1:0] mem_r [DEPTH];
    logic [PW-1:0] wp_r;
    logic [PW-1:0] rp_r;
    logic [PW:0]   cnt_r;
    logic          wr;
    logic          rd;

    assign in_ready  = cnt_r != (PW + 1)'(DEPTH);
    assign out_valid = cnt_r != '0;
    assign out_data  = mem_r[rp_r];
    assign wr        = in_valid && in_ready;
    assign rd        = out_valid && out_ready;

    always_ff @(posedge ref_clk) begin
        if (wr) begin
            mem_r[wp_r] <= in_data;
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            wp_r  <= '0;
            rp_r  <= '0;
            cnt_r <= '0;
        end else begin
            if (wr) begin
                wp_r <= wp_r + 1'b1;
            end
            if (rd) begin
                rp_r <= rp_r + 1'b1;
            end
            cnt_r <= cnt_r + (PW + 1)'(wr) - (PW + 1)'(rd);
        end
    end
endmodule

// file: verif/asim_sensor_model.sv
`timescale 1ns/1ps

module asim_sensor_model #(
    parameter logic [7:0] RD_BYTE = 8'ha5
) (
    input  wire logic scl,
    input  wire logic sda,
    input  wire logic ack_en,
    output logic      sda_oe
);
    int   bitn = 0;
    int   nb   = 0;
    logic rd   = 1'b0;

    initial sda_oe = 1'b0;
    always @(negedge sda) if (scl) begin
        bitn = 0;
        nb = 0;
        rd = 1'b0;
    end
    always @(posedge scl) begin
        bitn = bitn + 1;
        if (bitn == 8 && nb == 0) rd = sda;
        // A master nack ends the read, so the line is left free for the stop
        if (bitn == 9 && rd && nb > 0 && sda) rd = 1'b0;
    end
    always @(negedge scl) begin
        if (bitn == 9) begin
            bitn = 0;
            nb = nb + 1;
        end
        sda_oe = (bitn == 8) ? (!(rd && nb > 0) && ack_en)
                             : (bitn < 8 && rd && nb > 0 && !RD_BYTE[7 - bitn]);
    end
endmodule

// file: verif/aux_sensor_i2c_master_tb_top.sv
`timescale 1ns/1ps

module aux_sensor_i2c_master_tb_top
    import asim_pkg::*;
;
    logic ref_clk = 1'b0, sys_rst = 1'b1, bypass_en = 1'b0, spi_mode = 1'b0, master_en = 1'b1;
    logic sample_tick = 1'b0, ch4_start = 1'b0, fifo_rd = 1'b0, ack_en = 1'b1;
    logic host_scl_i = 1'b1, host_pull = 1'b0, sensor_pull = 1'b0;
    asim_chan_cfg_t [4:0] chan_cfg = '0;
    logic sensor_bus_clock_line_oe, sensor_bus_data_line_oe, bypass_active, ch4_done, nack_evt;
    logic mdl_oe;
    logic host_scl_o, host_scl_oe, host_sda_o, host_sda_oe, arb_lost_evt;
    logic sensor_bus_clock_line_o, sensor_bus_data_line_o;
    logic [191:0] ext_data;
    logic [7:0] ch4_rdata, fifo_rdata;
    logic [9:0] fifo_count;
    wire logic sensor_bus_clock_line_i = ~sensor_bus_clock_line_oe;
    wire logic sensor_bus_data_line_i = ~(sensor_bus_data_line_oe | mdl_oe | sensor_pull);
    // The host data line also sees the relay's own pull, so echo is exercised
    wire logic host_sda_i = ~(host_sda_oe | host_pull);
    int num_errors = 0;
    int checks = 0;

    always #10 ref_clk = ~ref_clk;

    asim_master dut (.ref_clk, .sys_rst, .bypass_en, .spi_mode, .master_en, .sample_tick,
        .ch4_start, .chan_cfg, .fifo_rd, .host_scl_i, .host_sda_i, .sensor_bus_clock_line_i,
        .sensor_bus_data_line_i, .host_scl_o, .host_scl_oe, .host_sda_o, .host_sda_oe,
        .sensor_bus_clock_line_o, .sensor_bus_clock_line_oe, .sensor_bus_data_line_o,
        .sensor_bus_data_line_oe, .bypass_active, .ext_data, .ch4_rdata, .ch4_done,
        .nack_evt, .arb_lost_evt, .fifo_rdata, .fifo_count);
    asim_sensor_model mdl (.scl(sensor_bus_clock_line_i), .sda(sensor_bus_data_line_i),
        .ack_en, .sda_oe(mdl_oe));

    task automatic give_verdict();
        if (num_errors == 0 && checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t: saw %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic wait_on(input int sel);
        for (int n = 0; n < 20000; n++) begin
            @(posedge ref_clk);
            if ((sel == 0 && ch4_done === 1'b1) || (sel == 1 && nack_evt === 1'b1)
                || (sel == 2 && fifo_count === 10'h2)
                || (sel == 3 && arb_lost_evt === 1'b1)) begin
                checks++;
                return;
            end
        end
        num_errors++;
        $display("Error at %0t: wait ran out", $time);
        give_verdict();
    endtask
    task automatic tick(input logic ch4);
        @(posedge ref_clk);
        sample_tick <= !ch4;
        ch4_start <= ch4;
        @(posedge ref_clk);
        sample_tick <= 1'b0;
        ch4_start <= 1'b0;
    endtask
    task automatic burst_read();
        @(posedge ref_clk);
        chan_cfg[0] <= '{1'b1, 1'b1, 1'b1, 7'h1e, 8'h03, 8'h00, 4'h2};
        tick(1'b0);
        wait_on(2);
        repeat (2) @(posedge ref_clk);
        chk(ext_data[15:0], 16'ha5a5);
        fifo_rd <= 1'b1;
        repeat (2) @(posedge ref_clk);
        fifo_rd <= 1'b0;
        repeat (2) @(posedge ref_clk);
        chk(fifo_rdata, 8'ha5);
        chk(fifo_count, 10'h0);
    endtask
    task automatic single_xfer(input logic rd, input logic ack);
        @(posedge ref_clk);
        ack_en <= ack;
        // Length above one on purpose: channel 4 must still move a single byte
        chan_cfg[4] <= '{1'b1, rd, 1'b0, 7'h0c, 8'h0a, 8'h5c, 4'h3};
        tick(1'b1);
        wait_on(ack ? 0 : 1);
        if (!ack) wait_on(0);
    endtask
    task automatic arb_loss();
        @(posedge ref_clk);
        // A sensor holding data low beats the master at its first released bit
        sensor_pull <= 1'b1;
        chan_cfg[4] <= '{1'b1, 1'b0, 1'b0, 7'h0c, 8'h0a, 8'h5c, 4'h1};
        tick(1'b1);
        wait_on(3);
        sensor_pull <= 1'b0;
        repeat (4) @(posedge ref_clk);
        chk({sensor_bus_clock_line_oe, sensor_bus_data_line_oe}, 2'h0);
    endtask
    task automatic pass_through();
        @(posedge ref_clk);
        bypass_en <= 1'b1;
        // Host clock toggles every 4 cycles, a 160 ns period
        repeat (4) begin
            repeat (4) @(posedge ref_clk);
            chk(sensor_bus_clock_line_oe, !host_scl_i);
            host_scl_i <= !host_scl_i;
        end
        host_pull <= 1'b1;
        repeat (4) @(posedge ref_clk);
        chk(sensor_bus_data_line_oe, 1'b1);
        host_pull <= 1'b0;
        repeat (12) @(posedge ref_clk);
        sensor_pull <= 1'b1;
        repeat (4) @(posedge ref_clk);
        chk(host_sda_oe, 1'b1);
        sensor_pull <= 1'b0;
        repeat (12) @(posedge ref_clk);
        chk({host_sda_oe, sensor_bus_data_line_oe}, 2'h0);
        chk({host_scl_oe, host_scl_o, host_sda_o}, 3'h0);
        chk({sensor_bus_clock_line_o, sensor_bus_data_line_o}, 2'h0);
        chk(bypass_active, 1'b1);
        spi_mode <= 1'b1;
        repeat (4) @(posedge ref_clk);
        chk(bypass_active, 1'b0);
    endtask

    initial begin
        repeat (12) @(posedge ref_clk);
        sys_rst <= 1'b0;
        repeat (2) @(posedge ref_clk);
        burst_read();
        single_xfer(1'b1, 1'b1);
        chk(ch4_rdata, 8'ha5);
        single_xfer(1'b0, 1'b0);
        ack_en <= 1'b1;
        arb_loss();
        pass_through();
        single_xfer(1'b1, 1'b1);
        chk(ch4_rdata, 8'ha5);
        give_verdict();
    end
endmodule
